// File: core/eeprom_loader_regs.vh
// Image layout, register offsets and fixed values for the EEPROM image loader
`ifndef EEPROM_LOADER_REGS_VH
`define EEPROM_LOADER_REGS_VH
// ==========================================
// Image byte positions
`define IMG_SIG_ADDR 6'h00
`define IMG_SIG_VALUE 8'ha5
`define IMG_STA_ADDR 6'h01
`define IMG_FS_POLL 6'h07
`define IMG_HS_POLL 6'h08
`define IMG_CFG_FLAGS 6'h09
`define IMG_LANG_LO 6'h0a
`define IMG_LANG_HI 6'h0b
`define IMG_DESC_BASE 6'h0c
`define IMG_WAKE_LO 6'h1e
`define IMG_WAKE_HI 6'h1f
`define IMG_PME_FLAGS 6'h20
`define IMG_LAST 6'h20
// ==========================================
// Descriptor selects
`define DESC_HS_DEV 4'h5
`define DESC_HS_CFG 4'h6
`define DESC_FS_DEV 4'h7
`define DESC_FS_CFG 4'h8
`define DESC_COUNT 4'h9
`define DESC_TYPE_DEV 8'h01
`define DESC_SIZE_DEV 8'h12
`define DESC_TYPE_CFG 8'h02
// ==========================================
// Configuration flag bits
`define CFG_SELF_PWR_BIT 0
`define CFG_RMT_WAKE_BIT 2
// ==========================================
// Register byte offsets
`define REG_CTRL 4'h0
`define REG_STA_LO 4'h4
`define REG_STA_HI 4'h8
`define REG_MISC 4'hc
`define CTRL_RELOAD_BIT 0
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// File: core/eeprom_config_image_loader.v
// Configuration image loader: reads the EEPROM image after reset, AXI4-Lite view
// Function
// - Descriptor offsets count 16-bit words
// - Zero descriptor length means built-in default
// - Zero-length field uses hardware default
// - No string descriptors, no language ID
// - Full-speed poll interval from byte 07h
// - Hi-speed poll 08h, config flags 09h
// - Language ID low 0Ah, high 0Bh
// - String length/offset pairs 0Ch to 15h
// - Hi-speed device 16h/17h, config offset 19h
// - Full-speed device 1Ah/1Bh, config 1Ch/1Dh
// - Byte 1Eh bits enable pin wakeup 7:0
// - Byte 1Fh pins 10:8, PME flags 20h
// - Device descriptor type 0x1, size 0x12
// - Configuration descriptor type forced 0x2
// - Bytes past 20h are never interpreted
// - Load after reset, refuse USB until done
// - Station address feeds address registers
// - Flag bit2 remote wakeup, bit0 self-powered
`timescale 1ns/100ps
`include "eeprom_loader_regs.vh"

module eeprom_config_image_loader #(
    parameter EE_AW = 9
) (
    input wire core_clk, // 250 MHz core clock
    input wire rstn, // Async reset, active low
    output reg ee_rd_req, // Byte read request, held until ack
    output reg [EE_AW-1:0] ee_rd_addr, // Byte address to read
    input wire ee_rd_ack, // One-cycle read done
    input wire [7:0] ee_rd_data, // Byte read, valid with ack
    input wire remote_wakeup_strap, // Strap pin, asynchronous
    output wire usb_ready, // USB may be served
    output wire [47:0] station_address, // Default Ethernet address
    output wire [7:0] fs_poll_interval, // Full-speed interrupt interval
    output wire [7:0] hs_poll_interval, // Hi-speed interrupt interval
    output wire [15:0] lang_id, // Language identifier
    output wire lang_id_supported, // Some string descriptor present
    output wire remote_wakeup_en, // Remote wakeup support
    output wire self_powered, // Self powered when high
    output wire [10:0] gpio_wake_en, // Pin wakeup enables
    output wire [7:0] gpio_pme_flags, // PME flag byte
    input wire fetch_req, // Descriptor byte request
    output wire fetch_ready, // Request taken when both high
    input wire [3:0] fetch_sel, // Descriptor select
    input wire [7:0] fetch_idx, // Byte index inside descriptor
    output reg fetch_valid, // One-cycle answer pulse
    output reg [7:0] fetch_data, // Answer byte
    output reg fetch_absent, // Use built-in default instead
    input wire s_axi_awvalid, // AXI write address valid
    output wire s_axi_awready, // AXI write address ready
    input wire [3:0] s_axi_awaddr, // AXI write address
    input wire s_axi_wvalid, // AXI write data valid
    output wire s_axi_wready, // AXI write data ready
    input wire [31:0] s_axi_wdata, // AXI write data
    input wire [3:0] s_axi_wstrb, // AXI byte enables
    output reg s_axi_bvalid, // AXI write response valid
    input wire s_axi_bready, // AXI write response ready
    output reg [1:0] s_axi_bresp, // AXI write response
    input wire s_axi_arvalid, // AXI read address valid
    output wire s_axi_arready, // AXI read address ready
    input wire [3:0] s_axi_araddr, // AXI read address
    output reg s_axi_rvalid, // AXI read data valid
    input wire s_axi_rready, // AXI read data ready
    output reg [31:0] s_axi_rdata, // AXI read data
    output reg [1:0] s_axi_rresp // AXI read response
);

    // ==========================================
    // States
    localparam [4:0] ST_LOAD = 5'b00001;
    localparam [4:0] ST_WAIT = 5'b00010;
    localparam [4:0] ST_IDLE = 5'b00100;
    localparam [4:0] ST_FETCH = 5'b01000;
    localparam [4:0] ST_START = 5'b10000;

    reg [4:0] state_q;
    reg [5:0] byte_q;
    reg [7:0] img_q [0:32];
    reg image_ok_q;
    reg load_done_q;
    reg reload_q;
    reg [3:0] sel_q;
    reg [7:0] idx_q;
    reg [2:0] strap_sync_q;
    reg strap_q;
    reg aw_q;
    reg w_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    integer i;

    // ==========================================
    // Strap: three stages, change accepted when last two agree
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_sync_q <= 3'h0;
            strap_q <= 1'b0;
        end else begin
            strap_sync_q <= {strap_sync_q[1:0], remote_wakeup_strap};
            if (strap_sync_q[1] == strap_sync_q[2])
                strap_q <= strap_sync_q[2];
        end
    end

    // ==========================================
    // Field view of the loaded image; invalid image leaves zero defaults, remote wakeup from the strap
    assign station_address = {img_q[6], img_q[5], img_q[4],
                              img_q[3], img_q[2], img_q[1]};
    assign fs_poll_interval = img_q[`IMG_FS_POLL];
    assign hs_poll_interval = img_q[`IMG_HS_POLL];
    assign lang_id = {img_q[`IMG_LANG_HI], img_q[`IMG_LANG_LO]};
    assign gpio_wake_en = {img_q[`IMG_WAKE_HI][2:0], img_q[`IMG_WAKE_LO]};
    assign gpio_pme_flags = img_q[`IMG_PME_FLAGS];
    assign self_powered = img_q[`IMG_CFG_FLAGS][`CFG_SELF_PWR_BIT];
    // Flags override the strap only when an image was found
    assign remote_wakeup_en = image_ok_q ? img_q[`IMG_CFG_FLAGS][`CFG_RMT_WAKE_BIT]
                                         : strap_q;
    // Language ID only when a string descriptor exists
    assign lang_id_supported = image_ok_q &&
        ((img_q[12] | img_q[14] | img_q[16] | img_q[18] | img_q[20]) != 8'h00);
    assign usb_ready = load_done_q;
    // A pending reload wins over a fetch, so ready must not promise one then
    assign fetch_ready = (state_q == ST_IDLE) && !reload_q;

    // ==========================================
    // Length and byte address of the selected descriptor
    wire [5:0] len_pos = `IMG_DESC_BASE + {1'b0, sel_q, 1'b0};
    wire [7:0] sel_len = image_ok_q ? img_q[len_pos] : 8'h00;
    wire [7:0] sel_off = img_q[len_pos + 6'h01];
    // Offset counts words, so the byte base is twice it
    wire [EE_AW-1:0] sel_base = {sel_off, 1'b0};
    wire sel_dev = (sel_q == `DESC_HS_DEV) || (sel_q == `DESC_FS_DEV);
    wire sel_cfg = (sel_q == `DESC_HS_CFG) || (sel_q == `DESC_FS_CFG);

    // ==========================================
    // Load sequence and descriptor fetch share the one EEPROM port
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_START;
            byte_q <= 6'h00;
            image_ok_q <= 1'b0;
            load_done_q <= 1'b0;
            ee_rd_req <= 1'b0;
            ee_rd_addr <= {EE_AW{1'b0}};
            sel_q <= 4'h0;
            idx_q <= 8'h00;
            fetch_valid <= 1'b0;
            fetch_data <= 8'h00;
            fetch_absent <= 1'b0;
            for (i = 0; i <= 32; i = i + 1)
                img_q[i] <= 8'h00;
        end else begin
            fetch_valid <= 1'b0;
            case (state_q)
                ST_START: begin
                    // Defaults stand until a good signature is seen
                    for (i = 0; i <= 32; i = i + 1)
                        img_q[i] <= 8'h00;
                    image_ok_q <= 1'b0;
                    load_done_q <= 1'b0;
                    byte_q <= `IMG_SIG_ADDR;
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    ee_rd_req <= 1'b1;
                    ee_rd_addr <= {{(EE_AW-6){1'b0}}, byte_q};
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (ee_rd_ack) begin
                        ee_rd_req <= 1'b0;
                        if (byte_q == `IMG_SIG_ADDR) begin
                            if (ee_rd_data == `IMG_SIG_VALUE) begin
                                image_ok_q <= 1'b1;
                                byte_q <= `IMG_STA_ADDR;
                                state_q <= ST_LOAD;
                            end else begin
                                load_done_q <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            img_q[byte_q] <= ee_rd_data;
                            // Bytes past the flag byte are user storage
                            if (byte_q == `IMG_LAST) begin
                                load_done_q <= 1'b1;
                                state_q <= ST_IDLE;
                            end else begin
                                byte_q <= byte_q + 6'h01;
                                state_q <= ST_LOAD;
                            end
                        end
                    end
                end
                ST_IDLE: begin
                    if (reload_q) begin
                        state_q <= ST_START;
                    end else if (fetch_req) begin
                        sel_q <= fetch_sel;
                        idx_q <= fetch_idx;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // Absent, out-of-range or past-the-end bytes go to defaults
                    if (sel_q >= `DESC_COUNT || sel_len == 8'h00 || idx_q >= sel_len) begin
                        fetch_valid <= 1'b1;
                        fetch_absent <= 1'b1;
                        fetch_data <= 8'h00;
                        state_q <= ST_IDLE;
                    end else if (sel_dev && idx_q == 8'h00) begin
                        fetch_valid <= 1'b1;
                        fetch_absent <= 1'b0;
                        fetch_data <= `DESC_SIZE_DEV;
                        state_q <= ST_IDLE;
                    end else if ((sel_dev || sel_cfg) && idx_q == 8'h01) begin
                        fetch_valid <= 1'b1;
                        fetch_absent <= 1'b0;
                        fetch_data <= sel_dev ? `DESC_TYPE_DEV : `DESC_TYPE_CFG;
                        state_q <= ST_IDLE;
                    end else if (!ee_rd_req) begin
                        ee_rd_req <= 1'b1;
                        ee_rd_addr <= sel_base + {{(EE_AW-8){1'b0}}, idx_q};
                    end else if (ee_rd_ack) begin
                        ee_rd_req <= 1'b0;
                        fetch_valid <= 1'b1;
                        fetch_absent <= 1'b0;
                        fetch_data <= ee_rd_data;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_START;
            endcase
        end
    end

    // ==========================================
    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
            reload_q <= 1'b0;
        end else begin
            // Reload request held until the loader restarts
            if (state_q == ST_START)
                reload_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_q && w_q) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == `REG_CTRL) begin
                    s_axi_bresp <= `AXI_OKAY;
                    if (wstrb_q[0] && wdata_q[`CTRL_RELOAD_BIT])
                        reload_q <= 1'b1;
                end else if (awaddr_q == `REG_STA_LO || awaddr_q == `REG_STA_HI ||
                             awaddr_q == `REG_MISC) begin
                    s_axi_bresp <= `AXI_OKAY; // Read-only: write ignored
                end else begin
                    s_axi_bresp <= `AXI_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // AXI4-Lite read: one outstanding, answer the cycle after the address
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            case (s_axi_araddr)
                `REG_CTRL: s_axi_rdata <= {25'h0, gpio_pme_flags[0] & 1'b0,
                    self_powered, remote_wakeup_en, lang_id_supported,
                    image_ok_q, load_done_q, reload_q};
                `REG_STA_LO: s_axi_rdata <= station_address[31:0];
                `REG_STA_HI: s_axi_rdata <= {16'h0, station_address[47:32]};
                `REG_MISC: s_axi_rdata <= {gpio_pme_flags, img_q[`IMG_CFG_FLAGS],
                    hs_poll_interval, fs_poll_interval};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// File: tb/eeprom_loader_asserts.sv
// Port checker for the configuration image loader
`timescale 1ns/100ps
`include "eeprom_loader_regs.vh"
// ==========================================
// Checker
module eeprom_loader_asserts #(
    parameter EE_AW = 9
) (
    input wire core_clk, // Core clock
    input wire rstn, // Async reset, active low
    input wire ee_rd_req, // Byte read request
    input wire [EE_AW-1:0] ee_rd_addr, // Byte address
    input wire ee_rd_ack, // Byte read done
    input wire usb_ready, // Load finished
    input wire fetch_req, // Fetch request
    input wire fetch_ready, // Fetch ready
    input wire fetch_valid, // Fetch answer
    input wire [7:0] fetch_data, // Fetch byte
    input wire fetch_absent, // Default used
    input wire [47:0] station_address, // Station address
    input wire [7:0] fs_poll_interval, // Full-speed poll
    input wire [7:0] hs_poll_interval, // Hi-speed poll
    input wire [7:0] gpio_pme_flags, // PME flags
    input wire lang_id_supported, // Language id offered
    input wire remote_wakeup_en, // Remote wakeup
    input wire self_powered, // Power method
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [3:0] s_axi_araddr, // Read address
    input wire s_axi_rvalid, // Read data valid
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp // Read response
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire ar_go = s_axi_arvalid && s_axi_arready;
    // Assertions
    a_usb_refused: assert property (!usb_ready |-> !fetch_ready)
        else $error("fetch accepted before load done");
    a_req_holds: assert property (ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_rd_addr))
        else $error("byte read request dropped or moved");
    a_load_range: assert property (ee_rd_req && !usb_ready |-> ee_rd_addr <= 'h20)
        else $error("load read past image end");
    a_fetch_answer: assert property (fetch_req && fetch_ready |-> ##[2:20] fetch_valid)
        else $error("fetch not answered");
    a_valid_pulse: assert property (fetch_valid |=> !fetch_valid)
        else $error("fetch valid longer than a cycle");
    a_absent_zero: assert property (fetch_valid && fetch_absent |-> fetch_data == 8'h00)
        else $error("absent byte not zero");
    a_sta_low: assert property (ar_go && s_axi_araddr == `REG_STA_LO |=>
        s_axi_rvalid && s_axi_rdata == station_address[31:0])
        else $error("station low register wrong");
    a_sta_high: assert property (ar_go && s_axi_araddr == `REG_STA_HI |=>
        s_axi_rdata == {16'h0000, station_address[47:32]})
        else $error("station high register wrong");
    a_misc_reg: assert property (ar_go && s_axi_araddr == `REG_MISC |=>
        s_axi_rdata[15:0] == {hs_poll_interval, fs_poll_interval}
        && s_axi_rdata[31:24] == gpio_pme_flags)
        else $error("misc register wrong");
    a_ctrl_flags: assert property (ar_go && s_axi_araddr == `REG_CTRL |=>
        s_axi_rdata[5:3] == {self_powered, remote_wakeup_en, lang_id_supported})
        else $error("status flags wrong");
    a_unmapped: assert property (ar_go && s_axi_araddr[1:0] != 2'b00 |=>
        s_axi_rresp == `AXI_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    // Main scenarios
    c_fetch_img: cover property (fetch_valid && !fetch_absent);
    c_fetch_dflt: cover property (fetch_valid && fetch_absent);
    c_load_done: cover property ($rose(usb_ready));
endmodule
bind eeprom_config_image_loader eeprom_loader_asserts #(.EE_AW(EE_AW)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
    .ee_rd_ack(ee_rd_ack), .usb_ready(usb_ready), .fetch_req(fetch_req),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .fetch_absent(fetch_absent), .station_address(station_address),
    .fs_poll_interval(fs_poll_interval), .hs_poll_interval(hs_poll_interval),
    .gpio_pme_flags(gpio_pme_flags), .lang_id_supported(lang_id_supported),
    .remote_wakeup_en(remote_wakeup_en), .self_powered(self_powered),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// File: tb/eeprom_model.sv
// Byte-level model of the serial configuration memory
`timescale 1ns/100ps
// ==========================================
// Memory model
module eeprom_model (
    input wire core_clk, // Core clock
    input wire rstn, // Async reset, active low
    input wire slow, // Long answer latency when high
    input wire ee_rd_req, // Byte read request
    input wire [8:0] ee_rd_addr, // Byte address
    output logic ee_rd_ack, // One-cycle done
    output logic [7:0] ee_rd_data // Byte, valid with ack only
);
    logic [7:0] mem [0:511];
    logic [2:0] cnt_q;
    // Outside ack the data is inverted every cycle, so a stale byte shows again on alternate cycles
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ee_rd_ack <= 1'b0;
            cnt_q <= 3'h0;
            ee_rd_data <= 8'h00;
        end else if (ee_rd_ack) begin
            ee_rd_ack <= 1'b0;
            cnt_q <= 3'h0;
            ee_rd_data <= ~ee_rd_data;
        end else if (ee_rd_req) begin
            cnt_q <= cnt_q + 3'h1;
            ee_rd_ack <= (cnt_q >= (slow ? 3'h5 : 3'h1));
            ee_rd_data <= (cnt_q >= (slow ? 3'h5 : 3'h1)) ? mem[ee_rd_addr] : ~ee_rd_data;
        end else begin
            ee_rd_data <= ~ee_rd_data;
        end
    end
endmodule

// File: tb/tb_top.sv
// Testbench for the configuration image loader
`timescale 1ns/100ps
`include "eeprom_loader_regs.vh"
module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic slow = 1'b0;
    logic strap = 1'b1;
    logic ee_rd_req, ee_rd_ack, usb_ready, lang_ok, rwake, selfp, fetch_ready, fetch_valid;
    logic fetch_absent, fetch_req = 1'b0;
    logic [8:0] ee_rd_addr;
    logic [7:0] ee_rd_data, fs_poll, hs_poll, pme, fetch_data, fetch_idx = 8'h00;
    logic [47:0] sta;
    logic [15:0] lang;
    logic [10:0] wake;
    logic [3:0] fetch_sel = 4'h0, awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    integer n_mismatch = 0, checked = 0, cyc = 0, i;
    always #2 core_clk = ~core_clk;
    eeprom_model u_ee (.core_clk(core_clk), .rstn(rstn), .slow(slow), .ee_rd_req(ee_rd_req),
        .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data));
    eeprom_config_image_loader uut (.core_clk(core_clk), .rstn(rstn), .ee_rd_req(ee_rd_req),
        .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data),
        .remote_wakeup_strap(strap), .usb_ready(usb_ready), .station_address(sta),
        .fs_poll_interval(fs_poll), .hs_poll_interval(hs_poll), .lang_id(lang),
        .lang_id_supported(lang_ok), .remote_wakeup_en(rwake), .self_powered(selfp),
        .gpio_wake_en(wake), .gpio_pme_flags(pme), .fetch_req(fetch_req),
        .fetch_ready(fetch_ready), .fetch_sel(fetch_sel), .fetch_idx(fetch_idx),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_absent(fetch_absent),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    // ==========================================
    // Tasks
    task finish_test;
        begin
            $display("checked %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input logic [47:0] seen, input logic [47:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] dv);
        begin
            @(posedge core_clk);
            awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= dv; bready <= 1'b1;
            do begin
                @(posedge core_clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            bready <= 1'b0;
            chk(bresp, `AXI_OKAY);
        end
    endtask
    task axi_rd(input logic [3:0] a);
        begin
            @(posedge core_clk);
            arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
            do begin
                @(posedge core_clk);
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            rready <= 1'b0;
            d = rdata;
            r = rresp;
        end
    endtask
    // Request stays up until the loader takes it
    task fetch_chk(input logic [3:0] s, input logic [7:0] x, input logic [7:0] e, input logic a);
        begin
            fetch_req <= 1'b1; fetch_sel <= s; fetch_idx <= x;
            do @(posedge core_clk); while (fetch_ready !== 1'b1);
            fetch_req <= 1'b0;
            do @(posedge core_clk); while (fetch_valid !== 1'b1);
            chk(fetch_data, e);
            chk(fetch_absent, a);
        end
    endtask
    task reload;
        begin
            axi_wr(`REG_CTRL, 32'h1);
            while (usb_ready !== 1'b0) @(posedge core_clk);
            while (usb_ready !== 1'b1) @(posedge core_clk);
        end
    endtask
    // Hang guard; whole run is well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end
    // ==========================================
    // Image and sequence
    initial begin
        for (i = 0; i < 512; i = i + 1) u_ee.mem[i] = i[7:0] ^ 8'h5a;
        for (i = 0; i < 7; i = i + 1) u_ee.mem[i] = i[7:0];
        u_ee.mem[0] = 8'ha5;
        for (i = 14; i < 22; i = i + 1) u_ee.mem[i] = 8'h00;
        u_ee.mem[7] = 8'h11; u_ee.mem[8] = 8'h22; u_ee.mem[9] = 8'h05;
        u_ee.mem[10] = 8'h09; u_ee.mem[11] = 8'h04; u_ee.mem[12] = 8'h04; u_ee.mem[13] = 8'h20;
        // Descriptors laid out apart: device 96..113, configs 116..133 and 136..153
        u_ee.mem[22] = 8'h12; u_ee.mem[23] = 8'h30; u_ee.mem[24] = 8'h12; u_ee.mem[25] = 8'h3a;
        u_ee.mem[26] = 8'h00; u_ee.mem[28] = 8'h12; u_ee.mem[29] = 8'h44;
        u_ee.mem[30] = 8'hc3; u_ee.mem[31] = 8'hfd; u_ee.mem[32] = 8'h81;
        u_ee.mem[98] = 8'h00; u_ee.mem[99] = 8'h02; u_ee.mem[103] = 8'h40; u_ee.mem[113] = 8'h01;
        // Index fields that would name an absent string stay zero
        u_ee.mem[111] = 8'h00; u_ee.mem[112] = 8'h00; u_ee.mem[122] = 8'h00;
        u_ee.mem[133] = 8'h00; u_ee.mem[142] = 8'h00; u_ee.mem[153] = 8'h00;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        while (usb_ready !== 1'b1) @(posedge core_clk);
        chk(sta, 48'h060504030201);
        chk({fs_poll, hs_poll, lang}, 48'h11220409);
        chk({wake, pme, rwake, selfp, lang_ok}, {11'h5c3, 8'h81, 3'b111});
        axi_rd(`REG_STA_LO); chk(d, 32'h04030201);
        axi_rd(`REG_STA_HI); chk(d, 32'h00000605);
        axi_rd(`REG_MISC); chk(d, 32'h81052211);
        axi_rd(`REG_CTRL); chk(d, 32'h3e);
        axi_rd(4'h2); chk({r, d}, {`AXI_SLVERR, 32'h0});
        fetch_chk(4'h0, 8'h00, u_ee.mem[64], 1'b0);
        fetch_chk(4'h0, 8'h03, u_ee.mem[67], 1'b0);
        fetch_chk(4'h0, 8'h04, 8'h00, 1'b1);
        fetch_chk(4'h1, 8'h00, 8'h00, 1'b1);
        fetch_chk(4'h5, 8'h00, `DESC_SIZE_DEV, 1'b0);
        fetch_chk(4'h5, 8'h01, `DESC_TYPE_DEV, 1'b0);
        fetch_chk(4'h5, 8'h03, u_ee.mem[99], 1'b0);
        fetch_chk(4'h6, 8'h02, u_ee.mem[118], 1'b0);
        fetch_chk(4'h7, 8'h00, 8'h00, 1'b1);
        fetch_chk(4'h8, 8'h01, `DESC_TYPE_CFG, 1'b0);
        fetch_chk(4'h8, 8'h10, u_ee.mem[152], 1'b0);
        fetch_chk(4'h9, 8'h00, 8'h00, 1'b1);
        // Slow memory, no strings, flags cleared: flags beat the strap
        slow <= 1'b1;
        u_ee.mem[12] = 8'h00; u_ee.mem[9] = 8'h00;
        reload;
        chk({lang_ok, rwake, selfp}, 3'b000);
        u_ee.mem[0] = 8'h00;
        reload;
        chk(sta, 48'h0);
        chk(rwake, 1'b1);
        axi_rd(`REG_CTRL); chk(d[2], 1'b0);
        fetch_chk(4'h0, 8'h00, 8'h00, 1'b1);
        finish_test;
    end
endmodule
